// [shared/dup_pkg.sv]
// constants, register map and carrier types for the dual serial channel block
package dup_pkg;
  // clock and rate limits
  localparam int unsigned CLK_HZ           = 250000000;
  localparam int unsigned MAX_BAUD         = 115200;
  localparam int unsigned MIN_BAUD         = 300;
  localparam int unsigned OVERSAMPLE       = 16;
  localparam int unsigned MID_SAMPLE       = 8;
  // prescale per oversample tick: 384/16, 64/16, 32/16, the first two halved when doubled
  localparam logic [4:0]  PRESC_T1         = 5'h18;
  localparam logic [4:0]  PRESC_T1_DBL     = 5'h0c;
  localparam logic [4:0]  PRESC_GEN0       = 5'h04;
  localparam logic [4:0]  PRESC_GEN0_DBL   = 5'h02;
  localparam logic [4:0]  PRESC_GEN1       = 5'h02;
  localparam logic [1:0]  T1_RELOAD_TOP    = 2'h3;
  // register offsets
  localparam logic [15:0] ADDR_POWER_CTRL  = 16'h0087;
  localparam logic [15:0] ADDR_BAUD_CTRL   = 16'h00d8;
  localparam logic [15:0] ADDR_MISC_CTRL   = 16'hfff1;
  localparam logic [15:0] ADDR_CH0_CTRL    = 16'h009b;
  localparam logic [15:0] ADDR_CH0_DATA    = 16'h009c;
  localparam logic [15:0] ADDR_CH1_CTRL    = 16'h009d;
  localparam logic [15:0] ADDR_CH1_DATA    = 16'h009e;
  localparam logic [15:0] ADDR_CH0_REL_LO  = 16'h00aa;
  localparam logic [15:0] ADDR_CH0_REL_HI  = 16'h00ba;
  localparam logic [15:0] ADDR_CH1_REL_LO  = 16'h00ab;
  localparam logic [15:0] ADDR_CH1_REL_HI  = 16'h00bb;
  // field positions
  localparam int unsigned PWR_DOUBLE_BIT   = 7;
  localparam int unsigned PWR_GF1_BIT      = 3;
  localparam int unsigned PWR_GF0_BIT      = 2;
  localparam int unsigned PWR_STOP_BIT     = 1;
  localparam int unsigned PWR_IDLE_BIT     = 0;
  localparam int unsigned BAUD_SRC_BIT     = 7;
  localparam int unsigned MISC_LPBK_BIT    = 1;
  localparam int unsigned MISC_SEL_BIT     = 0;
  localparam int unsigned CTL_NINE_BIT     = 7;
  localparam int unsigned CTL_TWO_STOP_BIT = 6;
  localparam int unsigned CTL_RX_EN_BIT    = 4;
  localparam int unsigned CTL_TX_NINTH_BIT = 3;
  localparam int unsigned CTL_RX_NINTH_BIT = 2;
  localparam int unsigned CTL_TX_DONE_BIT  = 1;
  localparam int unsigned CTL_RX_DONE_BIT  = 0;
  // reset values
  localparam logic [7:0]  RST_REG          = 8'h00;
  localparam logic [9:0]  RST_RELOAD       = 10'h000;

  typedef struct packed {
    logic       nine_bit;
    logic       two_stop;
    logic       rx_enable;
    logic       tx_ninth;
  } dup_cfg_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } dup_req_type;
endpackage : dup_pkg

// [verilog/dup_serial.sv]
// dual serial channels sharing one pin pair, with rate generators and control registers

// oversample tick generator: prescaler then 10-bit reload counter
module dup_rate_gen (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // setting
  input  wire logic [4:0] presc,
  input  wire logic [9:0] reload,
  // tick out
  output logic            tick
);
  import dup_pkg::*;
  logic [4:0] pre_cnt;
  logic [9:0] rel_cnt;
  logic       pre_end;

  assign pre_end = (pre_cnt >= presc - 5'h01);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pre_cnt <= 5'h00;
    else if (pre_end) pre_cnt <= 5'h00;
    else pre_cnt <= pre_cnt + 5'h01;
  end

  // counts from reload up to all ones: 1024 - reload prescaled steps
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rel_cnt <= 10'h000;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_end) begin
        if (rel_cnt == 10'h3ff) begin
          rel_cnt <= reload;
          tick    <= 1'b1;
        end else begin
          rel_cnt <= rel_cnt + 10'h001;
        end
      end
    end
  end
endmodule : dup_rate_gen

// one asynchronous channel, 16x oversampled, lsb first
module dup_channel (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // timing and setup
  input  wire logic               tick,
  input  wire dup_pkg::dup_cfg_type cfg,
  // transmit side
  input  wire logic               tx_start,
  input  wire logic [7:0]         tx_data,
  output logic                    txd,
  output logic                    tx_done,
  // receive side
  input  wire logic               rxd,
  output logic                    rx_done,
  output logic [7:0]              rx_data,
  output logic                    rx_ninth
);
  import dup_pkg::*;
  logic [11:0] tx_shift;
  logic [3:0]  tx_bits;
  logic [3:0]  tx_sub;
  logic [3:0]  rx_sub;
  logic [3:0]  rx_idx;
  logic        rx_busy;
  logic [9:0]  rx_shift;
  logic [3:0]  rx_total;

  // frame: start, 8 data, optional ninth, one or two stops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= 12'hfff;
      tx_bits  <= 4'h0;
      tx_sub   <= 4'h0;
      txd      <= 1'b1;
      tx_done  <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_bits == 4'h0) begin
        txd <= 1'b1;
        if (tx_start) begin
          tx_shift <= cfg.nine_bit ? {2'b11, cfg.tx_ninth, tx_data, 1'b0}
                                   : {3'b111, tx_data, 1'b0};
          tx_bits  <= 4'd10 + {3'h0, cfg.nine_bit} + {3'h0, cfg.two_stop};
          tx_sub   <= 4'h0;
        end
      end else if (tick) begin
        txd <= tx_shift[0];
        if (tx_sub == 4'hf) begin
          tx_shift <= {1'b1, tx_shift[11:1]};
          tx_bits  <= tx_bits - 4'h1;
          tx_done  <= (tx_bits == 4'h1);
        end
        tx_sub <= tx_sub + 4'h1;
      end
    end
  end

  assign rx_total = 4'd9 + {3'h0, cfg.nine_bit};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy  <= 1'b0;
      rx_sub   <= 4'h0;
      rx_idx   <= 4'h0;
      rx_shift <= 10'h000;
      rx_done  <= 1'b0;
      rx_data  <= 8'h00;
      rx_ninth <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (cfg.rx_enable && tick && !rxd) begin
          rx_busy <= 1'b1;
          rx_sub  <= 4'h1;
          rx_idx  <= 4'h0;
        end
      end else if (tick) begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub == 4'(MID_SAMPLE - 1)) begin
          if (rx_idx == 4'h0 && rxd) begin
            rx_busy <= 1'b0; // false start
          end else if (rx_idx == rx_total) begin
            rx_busy  <= 1'b0;
            rx_done  <= rxd;
            rx_data  <= cfg.nine_bit ? rx_shift[8:1] : rx_shift[9:2];
            rx_ninth <= cfg.nine_bit ? rx_shift[9] : rxd;
          end else begin
            rx_shift <= {rxd, rx_shift[9:1]};
            rx_idx   <= rx_idx + 4'h1;
          end
        end
      end
    end
  end
endmodule : dup_channel

// Functional notes
// - two independent channels, only one attached to the pin pair
// - a misc control bit picks which channel uses the pins
// - link runs at rates up to 115200 bits per second
// - device shifts each byte out least significant bit first
// - parity, one or two stop bits, 300 to 115200
// - channel 0 eight-bit or nine-bit frame, timed by generator or timer 1
// - channel 1 frame with ninth bit, own generator only
// - timer 1 rate is 2^double times clock over 384*(256-timer1 high)
// - channel 0 generator rate is 2^double times clock over 64*(1024-reload)
// - reload is high register bits 1:0 over low register bits 7:0
// - power control bit 7 doubles channel 0 rate
// - software writes and reads the ninth bit for eight-bit parity frames
// - parity of serial data offered to the cpu parity flag
// - power control bit 1 requests cpu stop
// - power control bit 0 requests cpu idle
// - power control bits 3 and 2 are plain flags, register resets to zero
// - select bit 1 routes channel 1, 0 routes channel 0
// - loopback feeds channel 0 to 1 at select 0, 1 to 0 at select 1
// - baud control bit 7 picks timer 1 at 0, generator at 1
module dup_serial (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // cpu register port
  input  wire dup_pkg::dup_req_type req,
  output logic [7:0]       rdata,
  // timer 1 high byte from the core
  input  wire logic [7:0]  timer1_high_byte,
  // serial pins
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  // cpu power requests
  output logic             cpu_stop_req,
  output logic             cpu_idle_req,
  // parity of received data for the accumulator flag
  output logic             chan0_parity,
  output logic             chan1_parity
);
  import dup_pkg::*;
  logic [7:0]  power_control_reg;
  logic [7:0]  baud_control_reg;
  logic [7:0]  misc_control_zero;
  logic [7:0]  ctrl0;
  logic [7:0]  ctrl1;
  logic [7:0]  buf0;
  logic [7:0]  buf1;
  logic [7:0]  rel0_lo;
  logic [1:0]  rel0_hi;
  logic [7:0]  rel1_lo;
  logic [1:0]  rel1_hi;
  logic [9:0]  chan0_reload_value;
  logic [9:0]  chan1_reload_value;
  logic        rx_meta;
  logic        rx_sync;
  logic        dbl;
  logic        src_gen;
  logic        sel;
  logic        lpbk;
  logic [4:0]  presc0;
  logic [9:0]  reload0;
  logic        tick0;
  logic        tick1;
  logic        tx0;
  logic        tx1;
  logic        rx0_in;
  logic        rx1_in;
  logic        tx0_done;
  logic        tx1_done;
  logic        rx0_done;
  logic        rx1_done;
  logic [7:0]  rx0_data;
  logic [7:0]  rx1_data;
  logic        rx0_ninth;
  logic        rx1_ninth;
  dup_cfg_type cfg0;
  dup_cfg_type cfg1;
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        start0;
  logic        start1;

  assign dbl     = power_control_reg[PWR_DOUBLE_BIT];
  assign src_gen = baud_control_reg[BAUD_SRC_BIT];
  assign sel     = misc_control_zero[MISC_SEL_BIT];
  assign lpbk    = misc_control_zero[MISC_LPBK_BIT];
  assign chan0_reload_value = {rel0_hi, rel0_lo};
  assign chan1_reload_value = {rel1_hi, rel1_lo};
  assign wr_ctrl0 = req.wr && req.addr == ADDR_CH0_CTRL;
  assign wr_ctrl1 = req.wr && req.addr == ADDR_CH1_CTRL;
  assign start0   = req.wr && req.addr == ADDR_CH0_DATA;
  assign start1   = req.wr && req.addr == ADDR_CH1_DATA;

  // power control: stop and idle are one-cycle requests
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_control_reg <= RST_REG;
      cpu_stop_req      <= 1'b0;
      cpu_idle_req      <= 1'b0;
    end else begin
      cpu_stop_req <= 1'b0;
      cpu_idle_req <= 1'b0;
      if (req.wr && req.addr == ADDR_POWER_CTRL) begin
        power_control_reg <= req.wdata & 8'h8c;
        cpu_stop_req      <= req.wdata[PWR_STOP_BIT];
        cpu_idle_req      <= req.wdata[PWR_IDLE_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      baud_control_reg  <= RST_REG;
      misc_control_zero <= RST_REG;
    end else begin
      if (req.wr && req.addr == ADDR_BAUD_CTRL) baud_control_reg <= req.wdata & 8'h80;
      if (req.wr && req.addr == ADDR_MISC_CTRL) misc_control_zero <= req.wdata & 8'h83;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rel0_lo <= RST_RELOAD[7:0];
      rel0_hi <= RST_RELOAD[9:8];
      rel1_lo <= RST_RELOAD[7:0];
      rel1_hi <= RST_RELOAD[9:8];
    end else if (req.wr) begin
      if (req.addr == ADDR_CH0_REL_LO) rel0_lo <= req.wdata;
      if (req.addr == ADDR_CH0_REL_HI) rel0_hi <= req.wdata[1:0];
      if (req.addr == ADDR_CH1_REL_LO) rel1_lo <= req.wdata;
      if (req.addr == ADDR_CH1_REL_HI) rel1_hi <= req.wdata[1:0];
    end
  end

  // control regs; hardware set of done flags wins over a clearing write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0 <= RST_REG;
      ctrl1 <= RST_REG;
    end else begin
      if (wr_ctrl0) ctrl0 <= req.wdata & 8'hdf;
      if (rx0_done) ctrl0[CTL_RX_NINTH_BIT] <= rx0_ninth;
      if (tx0_done) ctrl0[CTL_TX_DONE_BIT] <= 1'b1;
      if (rx0_done) ctrl0[CTL_RX_DONE_BIT] <= 1'b1;
      if (wr_ctrl1) ctrl1 <= req.wdata & 8'h5f;
      ctrl1[CTL_NINE_BIT] <= 1'b1;
      if (rx1_done) ctrl1[CTL_RX_NINTH_BIT] <= rx1_ninth;
      if (tx1_done) ctrl1[CTL_TX_DONE_BIT] <= 1'b1;
      if (rx1_done) ctrl1[CTL_RX_DONE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf0 <= RST_REG;
      buf1 <= RST_REG;
    end else begin
      if (rx0_done) buf0 <= rx0_data;
      if (rx1_done) buf1 <= rx1_data;
    end
  end

  // parity of the last received byte for the cpu flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan0_parity <= 1'b0;
      chan1_parity <= 1'b0;
    end else begin
      chan0_parity <= ^buf0;
      chan1_parity <= ^buf1;
    end
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (req.rd) begin
      case (req.addr)
        ADDR_POWER_CTRL: rdata <= power_control_reg;
        ADDR_BAUD_CTRL:  rdata <= baud_control_reg;
        ADDR_MISC_CTRL:  rdata <= misc_control_zero;
        ADDR_CH0_CTRL:   rdata <= ctrl0;
        ADDR_CH1_CTRL:   rdata <= ctrl1;
        ADDR_CH0_DATA:   rdata <= buf0;
        ADDR_CH1_DATA:   rdata <= buf1;
        ADDR_CH0_REL_LO: rdata <= rel0_lo;
        ADDR_CH0_REL_HI: rdata <= {6'h00, rel0_hi};
        ADDR_CH1_REL_LO: rdata <= rel1_lo;
        ADDR_CH1_REL_HI: rdata <= {6'h00, rel1_hi};
        default:         rdata <= 8'h00;
      endcase
    end
  end

  // rate selection; timer 1 path reuses the reload counter as 256 - high byte
  always_comb begin
    if (src_gen) begin
      presc0  = dbl ? PRESC_GEN0_DBL : PRESC_GEN0;
      reload0 = chan0_reload_value;
    end else begin
      presc0  = dbl ? PRESC_T1_DBL : PRESC_T1;
      reload0 = {T1_RELOAD_TOP, timer1_high_byte};
    end
  end

  dup_rate_gen u_rate0 (
    .clock  (clock),
    .rst_n  (rst_n),
    .presc  (presc0),
    .reload (reload0),
    .tick   (tick0)
  );

  dup_rate_gen u_rate1 (
    .clock  (clock),
    .rst_n  (rst_n),
    .presc  (PRESC_GEN1),
    .reload (chan1_reload_value),
    .tick   (tick1)
  );

  assign cfg0 = '{nine_bit:  ctrl0[CTL_NINE_BIT],
                  two_stop:  ctrl0[CTL_TWO_STOP_BIT],
                  rx_enable: ctrl0[CTL_RX_EN_BIT],
                  tx_ninth:  ctrl0[CTL_TX_NINTH_BIT]};
  assign cfg1 = '{nine_bit:  1'b1,
                  two_stop:  ctrl1[CTL_TWO_STOP_BIT],
                  rx_enable: ctrl1[CTL_RX_EN_BIT],
                  tx_ninth:  ctrl1[CTL_TX_NINTH_BIT]};

  dup_channel u_chan0 (
    .clock    (clock),
    .rst_n    (rst_n),
    .tick     (tick0),
    .cfg      (cfg0),
    .tx_start (start0),
    .tx_data  (req.wdata),
    .txd      (tx0),
    .tx_done  (tx0_done),
    .rxd      (rx0_in),
    .rx_done  (rx0_done),
    .rx_data  (rx0_data),
    .rx_ninth (rx0_ninth)
  );

  dup_channel u_chan1 (
    .clock    (clock),
    .rst_n    (rst_n),
    .tick     (tick1),
    .cfg      (cfg1),
    .tx_start (start1),
    .tx_data  (req.wdata),
    .txd      (tx1),
    .tx_done  (tx1_done),
    .rxd      (rx1_in),
    .rx_done  (rx1_done),
    .rx_data  (rx1_data),
    .rx_ninth (rx1_ninth)
  );

  // receive pin synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rxd_pin;
      rx_sync <= rx_meta;
    end
  end

  // pin routing, idle level one for the unattached receiver
  always_comb begin
    if (lpbk) begin
      rx0_in = sel ? tx1 : 1'b1;
      rx1_in = sel ? 1'b1 : tx0;
    end else begin
      rx0_in = sel ? 1'b1 : rx_sync;
      rx1_in = sel ? rx_sync : 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) txd_pin <= 1'b1;
    else txd_pin <= sel ? tx1 : tx0;
  end
endmodule : dup_serial

// [tb/dup_serial_assertions.sv]
// port-level checker for the dual serial block
module dup_serial_checker (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  // register port
  input wire dup_pkg::dup_req_type req,
  input wire logic [7:0]           rdata,
  // pin and requests
  input wire logic                 txd_pin,
  input wire logic                 cpu_stop_req,
  input wire logic                 cpu_idle_req,
  input wire logic                 chan0_parity
);
  timeunit 1ns;
  timeprecision 100ps;
  import dup_pkg::*;
  logic [7:0] pwr_shadow;
  wire pwr_wr = req.wr && req.addr == ADDR_POWER_CTRL;
  wire stop_wr = pwr_wr && req.wdata[PWR_STOP_BIT];
  wire idle_wr = pwr_wr && req.wdata[PWR_IDLE_BIT];
  wire mapped = req.addr inside {ADDR_POWER_CTRL, ADDR_BAUD_CTRL, ADDR_MISC_CTRL, ADDR_CH0_CTRL,
    ADDR_CH0_DATA, ADDR_CH1_CTRL, ADDR_CH1_DATA, ADDR_CH0_REL_LO, ADDR_CH0_REL_HI,
    ADDR_CH1_REL_LO, ADDR_CH1_REL_HI};
  // stored bits of the power register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_shadow <= 8'h00;
    end else if (pwr_wr) begin
      pwr_shadow <= req.wdata & 8'h8c;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  stop_pulse_a:
    assert property (stop_wr |=> cpu_stop_req ##1 (!cpu_stop_req || $past(stop_wr)))
    else $error("stop pulse wrong");
  stop_cause_a:
    assert property (cpu_stop_req |-> $past(stop_wr)) else $error("stop pulse without write");
  idle_pulse_a:
    assert property (idle_wr |=> cpu_idle_req ##1 (!cpu_idle_req || $past(idle_wr)))
    else $error("idle pulse wrong");
  idle_cause_a:
    assert property (cpu_idle_req |-> $past(idle_wr)) else $error("idle pulse without write");
  power_readback_a:
    assert property (req.rd && !req.wr && req.addr == ADDR_POWER_CTRL |=> rdata == $past(pwr_shadow))
    else $error("power register read back wrong");
  unmapped_read_a:
    assert property (req.rd && !mapped |=> rdata == 8'h00) else $error("unmapped read not zero");
  baud_reserved_a:
    assert property (req.rd && req.addr == ADDR_BAUD_CTRL |=> rdata[6:0] == 7'h00)
    else $error("baud reserved bits set");
  start_bit_a:
    assert property ($fell(txd_pin) |-> !txd_pin [*8]) else $error("serial bit too short");
  ch0_parity_a:
    assert property (req.rd && req.addr == ADDR_CH0_DATA |=> chan0_parity == ^rdata)
    else $error("channel 0 parity wrong");
endmodule : dup_serial_checker

bind dup_serial dup_serial_checker u_checker (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
  .txd_pin(txd_pin), .cpu_stop_req(cpu_stop_req), .cpu_idle_req(cpu_idle_req), .chan0_parity(chan0_parity));

// [tb/dup_host_model.sv]
// host side serial partner: sends and captures lsb-first frames
module dup_host_model (
  // clock
  input  wire logic clock,
  // serial lines
  input  wire logic from_dev,
  output logic      to_dev
);
  timeunit 1ns;
  timeprecision 100ps;
  // line idles high between frames
  initial to_dev = 1'b1;
  task automatic send(input logic [8:0] bits, input int nbits, input int period);
    @(posedge clock);
    to_dev <= 1'b0;
    repeat (period) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      to_dev <= bits[i];
      repeat (period) @(posedge clock);
    end
    to_dev <= 1'b1;
    repeat (period) @(posedge clock);
  endtask : send
  task automatic recv(input int nbits, input int period, output logic [8:0] bits, output logic ok);
    int n;
    bits = 9'h000;
    n = 0;
    while (from_dev !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    repeat (period / 2) @(posedge clock);
    ok = (n < 20000) && (from_dev === 1'b0);
    for (int i = 0; i < nbits; i++) begin
      repeat (period) @(posedge clock);
      bits[i] = from_dev;
    end
    repeat (period) @(posedge clock);
    ok = ok && (from_dev === 1'b1);
  endtask : recv
endmodule : dup_host_model

// [tb/tb_dual_uart_pin_select_baud.sv]
// self-checking bench for the dual serial block
module tb_dual_uart_pin_select_baud;
  timeunit 1ns;
  timeprecision 100ps;
  import dup_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  dup_req_type req = '0;
  logic [7:0]  timer1_high_byte = 8'hff;
  logic [7:0]  rdata;
  logic        txd_pin, rxd_pin, cpu_stop_req, cpu_idle_req, chan0_parity, chan1_parity;
  int          miscompares = 0;
  int          comparisons = 0;
  int          low_cnt;
  logic [8:0]  got;
  logic        ok;
  always #2 clock = ~clock;
  dup_serial u_dut (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata), .timer1_high_byte(timer1_high_byte),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .cpu_stop_req(cpu_stop_req), .cpu_idle_req(cpu_idle_req),
    .chan0_parity(chan0_parity), .chan1_parity(chan1_parity));
  dup_host_model u_host (.clock(clock), .from_dev(txd_pin), .to_dev(rxd_pin));
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clock);
    req <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clock);
    req <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    data = rdata;
  endtask : rd
  task automatic rd_chk(input string name, input logic [15:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    rd(addr, v);
    check(name, {1'b0, exp}, {1'b0, v});
  endtask : rd_chk
  // polls the receive-done flag, bounded
  task automatic wait_rx(input logic [15:0] addr);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 500 && v[0] !== 1'b1; i++) rd(addr, v);
    check("rx done", 9'h001, {8'h00, v[0]});
    if (v[0] !== 1'b1) print_verdict();
  endtask : wait_rx
  task automatic tx_chk(input string name, input logic [15:0] addr, input logic [7:0] data,
                        input int nbits, input int period, input logic [8:0] exp);
    fork
      u_host.recv(nbits, period, got, ok);
      wr(addr, data);
    join
    check(name, exp, got);
    check("frame", 9'h001, {8'h00, ok});
    if (ok !== 1'b1) print_verdict();
  endtask : tx_chk
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk("power", ADDR_POWER_CTRL, 8'h00);
    rd_chk("baud", ADDR_BAUD_CTRL, 8'h00);
    rd_chk("misc", ADDR_MISC_CTRL, 8'h00);
    rd_chk("ch1 ctrl", ADDR_CH1_CTRL, 8'h80);
    wr(16'h0001, 8'hff);
    rd_chk("unmapped", 16'h0001, 8'h00);
    wr(ADDR_POWER_CTRL, 8'hff);
    check("stop idle", 9'h003, {7'h00, cpu_stop_req, cpu_idle_req});
    rd_chk("power", ADDR_POWER_CTRL, 8'h8c);
    // channel 0 on its generator, doubled: 32 clocks a bit
    wr(ADDR_CH0_REL_LO, 8'hff);
    wr(ADDR_CH0_REL_HI, 8'hff);
    wr(ADDR_BAUD_CTRL, 8'h80);
    wr(ADDR_POWER_CTRL, 8'h80);
    wr(ADDR_CH0_CTRL, 8'h10);
    tx_chk("ch0 tx", ADDR_CH0_DATA, 8'ha5, 8, 32, 9'h0a5);
    u_host.send(9'h03c, 8, 32);
    wait_rx(ADDR_CH0_CTRL);
    rd_chk("ch0 rx", ADDR_CH0_DATA, 8'h3c);
    // two stops: done flag rises only after the second stop
    wr(ADDR_CH0_CTRL, 8'h50);
    tx_chk("ch0 2stop tx", ADDR_CH0_DATA, 8'hc3, 8, 32, 9'h0c3);
    repeat (24) @(posedge clock);
    rd_chk("ch0 2stop busy", ADDR_CH0_CTRL, 8'h50);
    repeat (32) @(posedge clock);
    rd_chk("ch0 2stop done", ADDR_CH0_CTRL, 8'h52);
    wr(ADDR_CH0_CTRL, 8'h10);
    // channel 1 on the pins, doubling ignored
    wr(ADDR_MISC_CTRL, 8'h01);
    wr(ADDR_CH1_REL_LO, 8'hff);
    wr(ADDR_CH1_REL_HI, 8'h03);
    wr(ADDR_CH1_CTRL, 8'h98);
    tx_chk("ch1 tx", ADDR_CH1_DATA, 8'h5a, 9, 32, 9'h15a);
    wr(ADDR_CH0_DATA, 8'h00);
    low_cnt = 0;
    repeat (400) begin
      @(posedge clock);
      low_cnt += int'(txd_pin !== 1'b1);
    end
    check("quiet pin", 9'h000, low_cnt[8:0]);
    u_host.send(9'h096, 9, 32);
    wait_rx(ADDR_CH1_CTRL);
    rd_chk("ch1 rx", ADDR_CH1_DATA, 8'h96);
    check("ch1 parity", 9'h000, {8'h00, chan1_parity});
    rd_chk("ch1 ctrl", ADDR_CH1_CTRL, 8'h9b);
    // channel 0 from timer 1
    wr(ADDR_MISC_CTRL, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h00);
    wr(ADDR_POWER_CTRL, 8'h00);
    @(posedge clock);
    timer1_high_byte <= 8'hfe;
    tx_chk("t1 tx", ADDR_CH0_DATA, 8'h81, 8, 768, 9'h081);
    // let the stop bit finish, a write to a busy transmitter is dropped
    repeat (500) @(posedge clock);
    wr(ADDR_POWER_CTRL, 8'h80);
    tx_chk("t1 dbl tx", ADDR_CH0_DATA, 8'h7e, 8, 384, 9'h07e);
    repeat (300) @(posedge clock);
    // loopback both ways
    wr(ADDR_BAUD_CTRL, 8'h80);
    wr(ADDR_CH1_CTRL, 8'h98);
    wr(ADDR_MISC_CTRL, 8'h02);
    wr(ADDR_CH0_DATA, 8'h6b);
    wait_rx(ADDR_CH1_CTRL);
    rd_chk("lpbk 0 to 1", ADDR_CH1_DATA, 8'h6b);
    check("ch1 parity", 9'h001, {8'h00, chan1_parity});
    wr(ADDR_CH0_CTRL, 8'h10);
    wr(ADDR_MISC_CTRL, 8'h03);
    wr(ADDR_CH1_DATA, 8'hc4);
    wait_rx(ADDR_CH0_CTRL);
    rd_chk("lpbk 1 to 0", ADDR_CH0_DATA, 8'hc4);
    check("ch0 parity", 9'h001, {8'h00, chan0_parity});
    print_verdict();
  end
endmodule : tb_dual_uart_pin_select_baud
